// >>> bpcs_top.sv
// byte-port configuration sequencer: port, jtag load and start-up
`include "bpcs_map.svh"
module bpcs_top (
  input  wire logic       mclk_i,
  input  wire logic       nrst_i,
  input  wire logic       program_n_i,
  input  wire logic       sel_n_i,
  input  wire logic       write_n_i,
  input  wire logic [7:0] data_i,
  output logic            busy_o,
  input  wire logic       fast_clock_i,
  input  wire logic       scan_load_i,
  input  wire logic       scan_shift_i,
  input  wire logic       scan_tdi_i,
  input  wire logic [2:0] mode_select_pins_i,
  output logic            scan_mode_o,
  input  wire logic       clear_status_i,
  output logic            clear_status_o,
  output logic            clear_status_oe_o,
  input  wire logic       done_line_i,
  output logic            done_o,
  input  wire logic [1:0] startup_opt_i,
  input  wire logic       dll_lock_i,
  output logic            global_tristate_o,
  output logic            global_set_reset_o,
  output logic            global_write_enable_o,
  output logic            aligned_o,
  output logic            word_vld_o,
  output logic [31:0]     word_o
);
  // all checks below run on the one clock and rest during reset
  default clocking cb_main @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);
  // ----------------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------------
  localparam int NS = 15;
  wire  [NS-1:0] raw = {program_n_i, sel_n_i, write_n_i, data_i,
                        scan_shift_i, scan_tdi_i, clear_status_i, done_line_i};
  logic [NS-1:0] s1_q;
  logic [NS-1:0] s2_q;
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s1_q <= {3'h7, 8'h00, 4'h0};
      s2_q <= {3'h7, 8'h00, 4'h0};
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end
  wire       prog_n  = s2_q[14];
  wire       sel_n   = s2_q[13];
  wire       wr_n    = s2_q[12];
  wire [7:0] dpins   = s2_q[11:4];
  wire       sh_en   = s2_q[3];
  wire       tdi     = s2_q[2];
  wire       clr_in  = s2_q[1];
  wire       done_ln = s2_q[0];

  // reverse lines so data line 0 becomes byte msb
  function automatic logic [7:0] bit_rev(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++)
      r[7-i] = v[i];
    return r;
  endfunction : bit_rev
  wire [7:0] pin_byte = bit_rev(dpins);

  // ----------------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------------
  bpcs_pkg::bpcs_seq_type st_q;
  logic [15:0] clr_cnt_q;
  wire opt_done = startup_opt_i[`BPCS_OPT_WAIT_DONE];
  wire opt_lock = startup_opt_i[`BPCS_OPT_WAIT_LOCK];
  // release gate: shared done and lock when chosen
  wire go_on    = (!opt_done || done_ln) && (!opt_lock || dll_lock_i);
  wire load_ph  = st_q == bpcs_pkg::SEQ_LOAD;
  logic load_end;
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_q      <= bpcs_pkg::SEQ_CLEAR;
      clr_cnt_q <= '0;
    end
    else if (!prog_n)
    begin
      st_q      <= bpcs_pkg::SEQ_CLEAR;
      clr_cnt_q <= '0;
    end
    else
    begin
      case (st_q)
        bpcs_pkg::SEQ_CLEAR:
        begin
          clr_cnt_q <= clr_cnt_q + 1'b1;
          if (clr_cnt_q == `BPCS_CLEAR_CYCLES - 16'h0001)
            st_q <= bpcs_pkg::SEQ_WAIT_INIT;
        end
        bpcs_pkg::SEQ_WAIT_INIT:
          if (clr_in)
            st_q <= bpcs_pkg::SEQ_LOAD;
        bpcs_pkg::SEQ_LOAD:
          if (load_end)
            st_q <= bpcs_pkg::SEQ_DONE_UP;
        bpcs_pkg::SEQ_DONE_UP:
          if (go_on)
            st_q <= bpcs_pkg::SEQ_GTS_OFF;
        bpcs_pkg::SEQ_GTS_OFF:
          if (go_on)
            st_q <= bpcs_pkg::SEQ_RUN;
        bpcs_pkg::SEQ_RUN:
          st_q <= bpcs_pkg::SEQ_RUN;
        default:
          st_q <= bpcs_pkg::SEQ_CLEAR;
      endcase
    end
  end
  // open drain clear status: low while clearing
  assign clear_status_o    = 1'b0;
  assign clear_status_oe_o = st_q == bpcs_pkg::SEQ_CLEAR;
  logic done_q;
  logic gts_q;
  logic gsr_q;
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      done_q <= 1'b0;
      gts_q  <= 1'b1;
      gsr_q  <= 1'b1;
    end
    else
    begin
      done_q <= st_q inside {bpcs_pkg::SEQ_DONE_UP, bpcs_pkg::SEQ_GTS_OFF,
                             bpcs_pkg::SEQ_RUN};
      gts_q  <= !(st_q inside {bpcs_pkg::SEQ_GTS_OFF, bpcs_pkg::SEQ_RUN});
      gsr_q  <= st_q != bpcs_pkg::SEQ_RUN;
    end
  end
  assign done_o                = done_q;
  assign global_tristate_o     = gts_q;
  assign global_set_reset_o    = gsr_q;
  assign global_write_enable_o = !gsr_q;

  // ----------------------------------------------------------------------------
  // byte port: abort detection and busy
  // ----------------------------------------------------------------------------
  logic sel_d1_q;
  logic wr_d1_q;
  logic [3:0] abort_q;
  // write level changed while select held on two edges
  wire dir_flip = !sel_n && !sel_d1_q && (wr_n != wr_d1_q);
  wire aborting = abort_q != 4'h0;
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sel_d1_q <= 1'b1;
      wr_d1_q  <= 1'b1;
      abort_q  <= '0;
    end
    else
    begin
      sel_d1_q <= sel_n;
      wr_d1_q  <= wr_n;
      if (dir_flip)
        abort_q <= `BPCS_ABORT_CYCLES;
      else if (aborting)
        abort_q <= abort_q - 4'h1;
    end
  end

  // ----------------------------------------------------------------------------
  // byte sources into the fifo
  // ----------------------------------------------------------------------------
  bpcs_stream_if fin ();
  bpcs_stream_if fout ();
  logic [2:0] bit_cnt_q;
  logic [7:0] bit_sh_q;
  logic       bit_vld_q;
  wire  scan_md = mode_select_pins_i == `BPCS_MODE_JTAG_A ||
                  mode_select_pins_i == `BPCS_MODE_JTAG_B;
  assign scan_mode_o = scan_md;
  // scan path usable whatever the mode pins, it needs the load instruction, shift enable and the load phase
  wire  scan_on = scan_load_i && sh_en && load_ph;
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      bit_cnt_q <= '0;
      bit_sh_q  <= '0;
      bit_vld_q <= 1'b0;
    end
    else
    begin
      bit_vld_q <= 1'b0;
      if (scan_on)
      begin
        bit_sh_q  <= {bit_sh_q[6:0], tdi};
        bit_cnt_q <= bit_cnt_q + 1'b1;
        bit_vld_q <= bit_cnt_q == 3'h7;
      end
    end
  end
  // busy: fast clock back-pressure or abort hold
  wire stall = fast_clock_i && !fin.ready;
  wire busy  = aborting || stall;
  assign busy_o = busy;
  // capture on edge with select and write low, busy low
  wire port_take = !sel_n && !wr_n && !busy && load_ph && !dir_flip;
  assign fin.valid = port_take || (bit_vld_q && !busy);
  assign fin.data  = bit_vld_q ? bit_sh_q : pin_byte;

  bpcs_fifo #(
    .WIDTH (`BPCS_FIFO_WIDTH),
    .DEPTH (`BPCS_FIFO_DEPTH)
  ) u_fifo (
    .mclk_i (mclk_i),
    .nrst_i (nrst_i),
    .in_s   (fin.snk),
    .out_s  (fout.src)
  );

  // drain one byte every other cycle at fast clock so the fifo can fill
  logic pace_q;
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      pace_q <= 1'b0;
    else
      pace_q <= !pace_q;
  end
  bpcs_stream_if hin ();
  assign hin.data  = fout.data;
  assign hin.valid = fout.valid && (!fast_clock_i || pace_q);
  assign fout.ready = hin.ready && (!fast_clock_i || pace_q);

  logic hunt_ready;
  bpcs_sync_hunt u_hunt (
    .mclk_i       (mclk_i),
    .nrst_i       (nrst_i),
    .lose_align_i (dir_flip || !prog_n),
    .in_s         (hin.snk),
    .aligned_o    (aligned_o),
    .word_vld_o   (word_vld_o),
    .word_o       (word_o)
  );
  assign hunt_ready = hin.ready;
  // load ends when an assembled word equals the end word 0000000d
  assign load_end = word_vld_o && word_o == 32'h0000000d;

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  // start-up release order
  sequence s_done_rise;
    !done_q ##1 done_q;
  endsequence
  sequence s_release;
    !gts_q && gsr_q ##1 !gsr_q;
  endsequence
  a_gts_after_done: assert property (
    s_done_rise ##0 (startup_opt_i == 2'h0) |=> !gts_q)
    else $error("tristate not released one cycle after done");
  a_startup_order: assert property (
    s_done_rise ##0 (startup_opt_i == 2'h0) |=> s_release)
    else $error("start-up releases out of order");
  a_gsr_after_gts: assert property (
    $fell(gts_q) && startup_opt_i == 2'h0 |=> !gsr_q)
    else $error("set/reset not released after tristate");
  a_run_outputs: assert property (
    st_q == bpcs_pkg::SEQ_RUN && prog_n |=> done_q && !gts_q)
    else $error("done or tristate wrong while running");
  // byte port aborts and busy
  a_abort_busy: assert property (
    dir_flip |=> busy_o [*4])
    else $error("busy dropped during abort");
  a_flip_busy: assert property (
    !sel_n && $past(!sel_n) && $changed(wr_n) |=> busy_o)
    else $error("write level change did not abort");
  a_busy_ends: assert property (
    dir_flip ##1 (!dir_flip) [*4] |=> !aborting)
    else $error("abort hold longer than expected");
  a_abort_align: assert property (
    dir_flip |=> !aligned_o)
    else $error("alignment kept after abort");
  a_slow_no_busy: assert property (
    !fast_clock_i && !aborting |-> !busy_o)
    else $error("busy raised at slow clock");
  a_no_take_busy: assert property (
    busy_o |-> !port_take)
    else $error("byte taken while busy");
  a_take_push: assert property (
    port_take && !bit_vld_q |-> fin.valid && fin.data == pin_byte)
    else $error("byte not presented to fifo");
  // sequencing and scan path
  a_clear_wait: assert property (
    st_q == bpcs_pkg::SEQ_WAIT_INIT && !clr_in && prog_n |=>
    st_q == bpcs_pkg::SEQ_WAIT_INIT)
    else $error("load entered while clear status low");
  a_load_gate: assert property (
    $rose(load_ph) |-> $past(clr_in))
    else $error("load phase entered without clear status high");
  a_init_release: assert property (
    st_q == bpcs_pkg::SEQ_WAIT_INIT |-> !clear_status_oe_o)
    else $error("clear status still driven after clearing");
  a_prog_restart: assert property (
    !prog_n |=> st_q == bpcs_pkg::SEQ_CLEAR ##1 !done_q)
    else $error("program did not restart sequence");
  a_scan_needs_load: assert property (
    bit_vld_q |-> $past(scan_on))
    else $error("scan byte formed outside scan load");
endmodule : bpcs_top

// >>> bpcs_map.svh
// constants of the byte-port configuration sequencer
`ifndef BPCS_MAP_SVH
`define BPCS_MAP_SVH
// ----------------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------------
`define BPCS_CLK_MHZ        40
`define BPCS_NOHS_LIMIT_MHZ 50
// clear phase length in cycles
`define BPCS_CLEAR_CYCLES   16'h0400
// cycles that an aborted operation keeps busy raised
`define BPCS_ABORT_CYCLES   4'h4
// bytes queued before busy is raised at fast clock by the drain side
`define BPCS_FIFO_DEPTH     32
`define BPCS_FIFO_WIDTH     8
// ----------------------------------------------------------------------------
// synchronisation word and mode codes
// ----------------------------------------------------------------------------
`define BPCS_SYNC_WORD      32'haa995566
`define BPCS_MODE_JTAG_A    3'h5
`define BPCS_MODE_JTAG_B    3'h1
// start-up option bits
`define BPCS_OPT_WAIT_DONE  0
`define BPCS_OPT_WAIT_LOCK  1
`endif

// >>> bpcs_pkg.sv
// types of the byte-port configuration sequencer
package bpcs_pkg;
  typedef enum logic [2:0] {
    SEQ_CLEAR,
    SEQ_WAIT_INIT,
    SEQ_LOAD,
    SEQ_DONE_UP,
    SEQ_GTS_OFF,
    SEQ_RUN
  } bpcs_seq_type;
endpackage : bpcs_pkg

// >>> bpcs_stream_if.sv
// byte stream carrier between the port front end and the fifo
interface bpcs_stream_if;
  logic [7:0] data;
  logic       valid;
  logic       ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : bpcs_stream_if

// >>> bpcs_fifo.sv
// byte fifo with valid and ready on both sides
module bpcs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic mclk_i,
  input  wire logic nrst_i,
  bpcs_stream_if.snk in_s,
  bpcs_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              push = in_s.valid && in_s.ready;
  wire              pop  = out_s.valid && out_s.ready;
  // honest full and empty flags
  assign in_s.ready  = cnt_q < (AW+1)'(DEPTH);
  assign out_s.valid = cnt_q != '0;
  assign out_s.data  = mem[rd_q];
  // ----------------------------------------------------------------------------
  // pointers and count
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // storage has no reset
  always_ff @(posedge mclk_i)
  begin
    if (push)
      mem[wr_q] <= in_s.data;
  end
  a_fifo_no_over: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    cnt_q == (AW+1)'(DEPTH) |-> !in_s.ready)
    else $error("fifo accepts while full");
endmodule : bpcs_fifo

// >>> bpcs_sync_hunt.sv
// byte to word assembly with synchronisation search
`include "bpcs_map.svh"
module bpcs_sync_hunt (
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  input  wire logic        lose_align_i,
  bpcs_stream_if.snk       in_s,
  output logic             aligned_o,
  output logic             word_vld_o,
  output logic [31:0]      word_o
);
  logic [31:0] shf_q;
  logic [1:0]  cnt_q;
  logic        aligned_q;
  logic        vld_q;
  wire         take     = in_s.valid;
  wire [31:0]  shf_nx   = {shf_q[23:0], in_s.data};
  wire         sync_hit = shf_nx == `BPCS_SYNC_WORD;
  assign in_s.ready = 1'b1;
  assign aligned_o  = aligned_q;
  assign word_vld_o = vld_q;
  assign word_o     = shf_q;
  // ----------------------------------------------------------------------------
  // hunt realigns on the byte where the pattern ends
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      shf_q     <= '0;
      cnt_q     <= '0;
      aligned_q <= 1'b0;
      vld_q     <= 1'b0;
    end
    else
    begin
      vld_q <= 1'b0;
      if (lose_align_i)
      begin
        aligned_q <= 1'b0;
        cnt_q     <= '0;
      end
      else if (take)
      begin
        shf_q <= shf_nx;
        if (!aligned_q)
        begin
          aligned_q <= sync_hit;
          cnt_q     <= '0;
        end
        else
        begin
          cnt_q <= cnt_q + 1'b1;
          vld_q <= cnt_q == 2'h3;
        end
      end
    end
  end
  a_hunt_no_words: assert property (
    @(posedge mclk_i) disable iff (!nrst_i) !aligned_q |=> !vld_q)
    else $error("word issued while unaligned");
endmodule : bpcs_sync_hunt

// >>> bpcs_ctrl_model.sv
// behavioural model of the external configuration controller
module bpcs_ctrl_model (
  input  wire logic       mclk_i,
  input  wire logic       busy_i,
  output logic            sel_n_o,
  output logic            write_n_o,
  output logic [7:0]      data_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] drv_q;
  logic [7:0] junk_q;

  // ----------------------------------------------------------------------
  // bus drivers
  // ----------------------------------------------------------------------
  // drivers are off unless selected and writing, so the bus wanders
  assign data_o = (sel_n_o | write_n_o) ? junk_q : drv_q;

  // idle pattern changes every cycle so stale data is never seen
  always @(posedge mclk_i)
    junk_q <= ~junk_q;

  // idle state of the pins at time zero
  initial
  begin
    sel_n_o = 1'b1;
    write_n_o = 1'b1;
    drv_q = 8'h00;
    junk_q = 8'h5a;
  end

  // ----------------------------------------------------------------------
  // transfer tasks, each entered and left just after a rising edge
  // ----------------------------------------------------------------------
  // byte msb goes out on data line 0
  function automatic logic [7:0] flip(input logic [7:0] b);
    for (int i = 0; i < 8; i++)
      flip[i] = b[7 - i];
  endfunction : flip

  // one byte, held until an edge sees busy low
  task automatic send_byte(input logic [7:0] b);
    logic seen;
    sel_n_o = 1'b0;
    write_n_o = 1'b0;   // write level constant while selected
    drv_q = flip(b);
    forever
    begin
      seen = busy_i;
      @(posedge mclk_i);
      if (seen !== 1'b1)
        break;
    end
    #2;
  endtask : send_byte

  // four bytes, most significant first
  task automatic send_word(input logic [31:0] w);
    for (int i = 3; i >= 0; i--)
      send_byte(w[8 * i +: 8]);
  endtask : send_word

  // end the selection for one cycle
  task automatic drop();
    sel_n_o = 1'b1;
    write_n_o = 1'b1;
    @(posedge mclk_i);
    #2;
  endtask : drop

  // write strobe released with select held: a deliberate abort
  task automatic abort();
    sel_n_o = 1'b0;
    write_n_o = 1'b0;
    @(posedge mclk_i);
    #2;
    write_n_o = 1'b1;
    repeat (2) @(posedge mclk_i);
    #2;
    drop();
  endtask : abort
endmodule : bpcs_ctrl_model

// >>> bpcs_top_test.sv
// self-checking testbench of the byte-port configuration sequencer
`include "bpcs_map.svh"
module bpcs_top_test;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [31:0] END_WORD = 32'h0000000d;
  logic mclk = 1'b0;
  logic nrst, program_n, fast_clock, scan_load, scan_shift, scan_tdi;
  logic ext_clear, done_line, dll_lock, abort_win, run;
  logic [2:0] mode;
  logic [1:0] opt;
  wire sel_n, write_n, clear_line;
  wire [7:0] data;
  logic busy, scan_mode, cs_o, cs_oe, done, global_tristate, global_set_reset, global_write_enable;
  logic aligned, word_vld;
  logic [31:0] word, w;
  logic [31:0] wq[$];
  int err_count, n_tests, cycles, seed, cnt, bcnt;

  // ----------------------------------------------------------------------
  // clock, wiring and instances
  // ----------------------------------------------------------------------
  always #12.5 mclk = ~mclk;

  // open-drain clear-status line with an external pull-down option
  assign clear_line = ~(cs_oe & ~cs_o) & ext_clear;

  bpcs_ctrl_model ctl (.mclk_i(mclk), .busy_i(busy), .sel_n_o(sel_n),
    .write_n_o(write_n), .data_o(data));

  bpcs_top dut (.mclk_i(mclk), .nrst_i(nrst), .program_n_i(program_n),
    .sel_n_i(sel_n), .write_n_i(write_n), .data_i(data), .busy_o(busy),
    .fast_clock_i(fast_clock), .scan_load_i(scan_load),
    .scan_shift_i(scan_shift), .scan_tdi_i(scan_tdi),
    .mode_select_pins_i(mode), .scan_mode_o(scan_mode),
    .clear_status_i(clear_line), .clear_status_o(cs_o),
    .clear_status_oe_o(cs_oe), .done_line_i(done_line), .done_o(done),
    .startup_opt_i(opt), .dll_lock_i(dll_lock),
    .global_tristate_o(global_tristate), .global_set_reset_o(global_set_reset),
    .global_write_enable_o(global_write_enable), .aligned_o(aligned),
    .word_vld_o(word_vld), .word_o(word));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : tick

  // shift one word into the scan data path, msb first
  task automatic shift_word(input logic [31:0] v);
    for (int b = 31; b >= 0; b--)
    begin
      scan_tdi = v[b];
      tick(1);
    end
  endtask : shift_word

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------------
  // monitors and timeout
  // ----------------------------------------------------------------------
  // assembled words against the queue, busy only inside abort windows
  always @(negedge mclk)
  begin
    if (word_vld === 1'b1 && word !== `BPCS_SYNC_WORD)
      check(word, wq.size() ? wq.pop_front() : 32'hxxxxxxxx);
    if (run && !abort_win && busy !== 1'b0)
      check({31'h0, busy}, 32'h0);
    if (abort_win && busy === 1'b1)
      bcnt++;
  end

  // cut a hang short
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      final_report();
    end
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    {nrst, program_n, fast_clock, scan_load, scan_shift} = 5'b01000;
    {scan_tdi, ext_clear, done_line, dll_lock, abort_win} = 5'b00110;
    {run, mode, opt} = 6'h00;
    seed = 70;
    tick(8);
    nrst = 1'b1;
    run = 1'b1;
    check({26'h0, global_tristate, global_set_reset, global_write_enable, done, busy, cs_oe}, 32'h31);
    for (int i = 0; i < 8; i++)
    begin
      mode = i[2:0];
      #1;
      check({31'h0, scan_mode}, {31'h0, i == 5 || i == 1});
    end
    $display("test mode pins finished");
    cnt = 0;
    while (cs_oe === 1'b1 && cnt < 1200)
    begin
      tick(1);
      cnt++;
    end
    check({31'h0, cnt >= 1020 && cnt <= 1030}, 32'h1);
    ctl.send_word(`BPCS_SYNC_WORD);
    ctl.send_word(END_WORD);
    ctl.drop();
    tick(20);
    check({30'h0, aligned, done}, 32'h0);
    ext_clear = 1'b1;
    tick(4);
    $display("test clear hold finished");
    ctl.send_word(`BPCS_SYNC_WORD);
    for (int i = 0; i < 6; i++)
    begin
      w = $random(seed);
      wq.push_back(w);
      ctl.send_word(w);
      if (w[0] || i == 5)
        ctl.drop();
    end
    tick(12);
    check({31'h0, aligned}, 32'h1);
    bcnt = 0;
    abort_win = 1'b1;
    ctl.abort();
    tick(20);
    abort_win = 1'b0;
    check({31'h0, bcnt >= 4 && bcnt <= 6}, 32'h1);
    for (int i = 0; i < 2; i++)
      ctl.send_word($random(seed));
    ctl.drop();
    tick(12);
    check({31'h0, aligned}, 32'h0);
    ctl.send_word(`BPCS_SYNC_WORD);
    w = $random(seed);
    wq.push_back(w);
    wq.push_back(END_WORD);
    ctl.send_word(w);
    ctl.send_word(END_WORD);
    ctl.drop();
    $display("test byte load and abort finished");
    cnt = 0;
    while (done !== 1'b1 && cnt < 100)
    begin
      tick(1);
      cnt++;
    end
    check({29'h0, done, global_tristate, global_set_reset}, 32'h7);
    tick(1);
    check({29'h0, global_tristate, global_set_reset, global_write_enable}, 32'h2);
    tick(1);
    check({29'h0, global_tristate, global_set_reset, global_write_enable}, 32'h1);
    $display("test start-up finished");
    program_n = 1'b0;
    tick(4);
    program_n = 1'b1;
    tick(6);
    check({29'h0, done, global_tristate, cs_oe}, 32'h3);
    cnt = 0;
    while (cs_oe === 1'b1 && cnt < 1200)
    begin
      tick(1);
      cnt++;
    end
    $display("test restart finished");
    tick(4);
    {opt, done_line, dll_lock, scan_load, scan_shift} = 6'h33;
    shift_word(`BPCS_SYNC_WORD);
    wq.push_back(END_WORD);
    shift_word(END_WORD);
    scan_shift = 1'b0;
    tick(20);
    check({30'h0, done, global_tristate}, 32'h3);
    done_line = 1'b1;
    tick(20);
    check({31'h0, global_tristate}, 32'h1);
    dll_lock = 1'b1;
    tick(10);
    check({31'h0, global_tristate}, 32'h0);
    $display("test scan load finished");
    final_report();
  end
endmodule : bpcs_top_test
